// file: hw/spr_group.sv
// Channel control, bank guard, timer and pipeline address register group
//
// Overview of operation
// - Channel control rewritten on every load/store transfer unless freeze is set.
// - Bits 31-24 copy instruction bits 23-16 of the starting load/store.
// - Bits 23-16 give remaining transfers minus one for interrupted multiples.
// - Bit 15 is one for loads, zero for stores.
// - Bit 14 set only for a partially finished multiple transfer.
// - Bit 13 set for load-and-set transactions.
// - Bit 12 set only for lock instructions, never from the CPU lock bit.
// - Bit 10 set only by data errors; raises data or coprocessor trap; software clears.
// - Bits 9-2 hold absolute operand register number after stack-pointer offset.
// - Bit 1 marks an incomplete load whose result is overwritten later.
// - Bit 0 says the channel record is valid.
// - Registers form 16 banks of 16, bank 0 holding only 12.
// - Guard bit one makes User access to that bank trap.
// - Supervisor and Monitor accesses skip the bank check.
// - Bank check uses absolute register numbers.
// - 24-bit count falls each clock, reloads at zero and sets expired.
// - Overrun set if expired is already one at zero.
// - Expired set at every zero; interrupt when expired and allowed.
// - Zero held one cycle, so value N expires N+1 cycles later.
// - Allow bit gates the interrupt; global trap disable suppresses it.
// - Decode address captures each decode entry, holds under freeze; low bits zero.
// - Execute address captures each execute entry, holds under freeze.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module spr_group
  import spr_group_pkg::*;
#(
  parameter int unsigned REG_NUM_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Channel transfer events from the load/store unit
  input wire logic xfer_valid,
  input wire logic [7:0] xfer_insn_bits,
  input wire logic [7:0] xfer_remaining,
  input wire logic xfer_is_load,
  input wire logic xfer_is_multi_partial,
  input wire logic xfer_is_set,
  input wire logic xfer_is_lock,
  input wire logic [REG_NUM_W-1:0] xfer_reg_num,
  input wire logic xfer_coproc_select,
  input wire logic data_error_input,
  input wire logic load_overwritten,
  input wire logic record_invalidate,
  // Register file access check
  input wire logic gpr_access,
  input wire logic [REG_NUM_W-1:0] gpr_abs_num,
  // Pipeline addresses
  input wire logic decode_enter,
  input wire logic [31:0] decode_pc,
  input wire logic execute_enter,
  input wire logic [31:0] execute_pc,
  // Outputs
  output logic data_access_trap,
  output logic coproc_trap,
  output logic protection_trap,
  output logic timer_irq,
  output logic freeze_bit,
  output logic [31:0] restart_decode_addr,
  output logic [31:0] restart_execute_addr
);
  initial begin
    if (REG_NUM_W != 8) $error("spr_group: REG_NUM_W must be 8");
  end

  // Bank index from an absolute register number; bank 0 holds only its top 12 slots
  function automatic logic [3:0] bank_of(input logic [REG_NUM_W-1:0] n);
    bank_of = n[7:4];
  endfunction

  function automatic logic bank_exists(input logic [REG_NUM_W-1:0] n);
    bank_exists = (n[7:4] != 4'h0) || (n[3:0] >= 4'(BANK_SIZE - BANK0_SIZE));
  endfunction

  logic [31:0] chan_r;
  logic [NUM_BANKS-1:0] guard_r;
  logic [29:0] pc_dec_r;
  logic [29:0] pc_exe_r;
  logic [4:0] status_r;
  logic coproc_r;
  chan_state_e chan_state_r;
  logic [TIMER_W-1:0] tcount;
  logic [TIMER_W-1:0] treload;
  logic texpired;
  logic toverrun;
  logic tzero;
  logic wr_chan;
  logic wr_guard;
  logic wr_tcount;
  logic wr_treload;
  logic wr_dec;
  logic wr_exe;
  logic wr_status;
  logic user_mode;
  logic [31:0] rdata_nxt;
  logic fault_set;

  always_comb begin
    wr_chan = 1'b0;
    wr_guard = 1'b0;
    wr_tcount = 1'b0;
    wr_treload = 1'b0;
    wr_dec = 1'b0;
    wr_exe = 1'b0;
    wr_status = 1'b0;
    if (reg_wr && reg_addr == OFF_CHANNEL_CONTROL) begin
      wr_chan = 1'b1;
    end else if (reg_wr && reg_addr == OFF_BANK_GUARD) begin
      wr_guard = 1'b1;
    end else if (reg_wr && reg_addr == OFF_TIMER_COUNT) begin
      wr_tcount = 1'b1;
    end else if (reg_wr && reg_addr == OFF_TIMER_RELOAD) begin
      wr_treload = 1'b1;
    end else if (reg_wr && reg_addr == OFF_DECODE_ADDR) begin
      wr_dec = 1'b1;
    end else if (reg_wr && reg_addr == OFF_EXECUTE_ADDR) begin
      wr_exe = 1'b1;
    end else if (reg_wr && reg_addr == OFF_CORE_STATUS) begin
      wr_status = 1'b1;
    end
  end

  spr_timer #(
    .WIDTH(TIMER_W)
  ) u_timer (
    .clk(clk),
    .nrst(nrst),
    .count_wr(wr_tcount),
    .count_wdata(reg_wdata[TIMER_W-1:0]),
    .reload_wr(wr_treload),
    .reload_wdata(reg_wdata[TIMER_W-1:0]),
    .expired_wdata(reg_wdata[TR_EXPIRED_BIT]),
    .overrun_wdata(reg_wdata[TR_OVERRUN_BIT]),
    .count_r(tcount),
    .reload_r(treload),
    .expired_r(texpired),
    .overrun_r(toverrun),
    .zero_hit(tzero)
  );

  logic allow_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      allow_r <= 1'b0;
    end else if (wr_treload) begin
      allow_r <= reg_wdata[TR_ALLOW_BIT];
    end
  end

  // Status bits that live outside this group in a full core; held here
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_r <= 5'b0_0100;
    end else if (wr_status) begin
      status_r <= reg_wdata[4:0];
    end
  end
  assign user_mode = !status_r[CS_SUPER_BIT] && !status_r[CS_MONITOR_BIT];

  assign fault_set = xfer_valid && data_error_input && !status_r[CS_FREEZE_BIT];

  // Channel control: a transfer rewrites the whole record; a data error sets the fault
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chan_r <= RESET_WORD;
      coproc_r <= 1'b0;
    end else if (xfer_valid && !status_r[CS_FREEZE_BIT]) begin
      chan_r[31:CC_INSN_LSB] <= xfer_insn_bits;
      chan_r[23:CC_COUNT_LSB] <= xfer_is_multi_partial ? xfer_remaining : 8'h00;
      chan_r[CC_DIR_BIT] <= xfer_is_load;
      chan_r[CC_MULTI_BIT] <= xfer_is_multi_partial;
      chan_r[CC_SET_BIT] <= xfer_is_set;
      chan_r[CC_LOCK_BIT] <= xfer_is_lock;
      chan_r[11] <= 1'b0;
      chan_r[CC_FAULT_BIT] <= data_error_input;
      chan_r[9:CC_REG_LSB] <= xfer_reg_num;
      chan_r[CC_UNUSED_BIT] <= xfer_is_load && load_overwritten;
      chan_r[CC_VALID_BIT] <= 1'b1;
      coproc_r <= xfer_coproc_select;
    end else begin
      if (wr_chan) begin
        // Software may clear the fault bit but never set it
        chan_r <= (reg_wdata & 32'hffff_f3ff)
                  | {21'h00_0000, reg_wdata[CC_FAULT_BIT] & chan_r[CC_FAULT_BIT], 10'h000};
      end
      // Hardware updates come last so they win over a software write in the same cycle
      if (load_overwritten && chan_r[CC_DIR_BIT] && chan_r[CC_VALID_BIT]) begin
        chan_r[CC_UNUSED_BIT] <= 1'b1;
      end
      if (record_invalidate) begin
        chan_r[CC_VALID_BIT] <= 1'b0;
      end
    end
  end

  // Tracks whether the channel holds an unfinished multiple or a pending fault
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chan_state_r <= CH_IDLE;
    end else begin
      case (chan_state_r)
        CH_IDLE: begin
          if (fault_set) chan_state_r <= CH_FAULT;
          else if (xfer_valid && xfer_is_multi_partial && !status_r[CS_FREEZE_BIT]) chan_state_r <= CH_MULTI;
        end
        CH_MULTI: begin
          if (fault_set) chan_state_r <= CH_FAULT;
          else if (xfer_valid && !xfer_is_multi_partial && !status_r[CS_FREEZE_BIT]) chan_state_r <= CH_IDLE;
        end
        CH_FAULT: begin
          if (!chan_r[CC_FAULT_BIT] && !fault_set) chan_state_r <= CH_IDLE;
        end
        default: chan_state_r <= CH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      guard_r <= '0;
    end else if (wr_guard) begin
      guard_r <= reg_wdata[NUM_BANKS-1:0];
    end
  end

  // Pipeline address capture, frozen while freeze is set
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pc_dec_r <= '0;
    end else if (decode_enter && !status_r[CS_FREEZE_BIT]) begin
      pc_dec_r <= decode_pc[31:2];
    end else if (wr_dec) begin
      pc_dec_r <= reg_wdata[31:2];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pc_exe_r <= '0;
    end else if (execute_enter && !status_r[CS_FREEZE_BIT]) begin
      pc_exe_r <= execute_pc[31:2];
    end else if (wr_exe) begin
      pc_exe_r <= reg_wdata[31:2];
    end
  end

  // Trap and interrupt outputs, registered
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_access_trap <= 1'b0;
      coproc_trap <= 1'b0;
      protection_trap <= 1'b0;
      timer_irq <= 1'b0;
      freeze_bit <= 1'b0;
      restart_decode_addr <= RESET_WORD;
      restart_execute_addr <= RESET_WORD;
    end else begin
      data_access_trap <= chan_r[CC_FAULT_BIT] && !coproc_r;
      coproc_trap <= chan_r[CC_FAULT_BIT] && coproc_r;
      // Absolute numbers come in already offset by the stack pointer
      protection_trap <= gpr_access && user_mode && bank_exists(gpr_abs_num)
                         && guard_r[bank_of(gpr_abs_num)];
      timer_irq <= texpired && allow_r && !status_r[CS_TRAP_DIS_BIT];
      freeze_bit <= status_r[CS_FREEZE_BIT];
      restart_decode_addr <= {pc_dec_r, 2'b00};
      restart_execute_addr <= {pc_exe_r, 2'b00};
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_addr == OFF_CHANNEL_CONTROL) begin
      rdata_nxt = chan_r;
    end else if (reg_addr == OFF_BANK_GUARD) begin
      rdata_nxt = {16'h0000, guard_r};
    end else if (reg_addr == OFF_TIMER_COUNT) begin
      rdata_nxt = {8'h00, tcount};
    end else if (reg_addr == OFF_TIMER_RELOAD) begin
      rdata_nxt = {5'b0_0000, toverrun, texpired, allow_r, treload};
    end else if (reg_addr == OFF_DECODE_ADDR) begin
      rdata_nxt = {pc_dec_r, 2'b00};
    end else if (reg_addr == OFF_EXECUTE_ADDR) begin
      rdata_nxt = {pc_exe_r, 2'b00};
    end else if (reg_addr == OFF_CORE_STATUS) begin
      rdata_nxt = {27'h000_0000, status_r};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rdata_nxt : 32'h0000_0000;
    end
  end

  property p_chan_rewrite;
    @(posedge clk) disable iff (!nrst)
    (xfer_valid && !status_r[CS_FREEZE_BIT]) |=> chan_r[31:24] == $past(xfer_insn_bits) && chan_r[CC_VALID_BIT];
  endproperty
  a_chan_rewrite: assert property (p_chan_rewrite) else $error("channel record not rewritten");

  property p_chan_frozen;
    @(posedge clk) disable iff (!nrst)
    (status_r[CS_FREEZE_BIT] && !wr_chan && !wr_status) |=> $stable(chan_r[31:2]);
  endproperty
  a_chan_frozen: assert property (p_chan_frozen) else $error("channel changed while frozen");

  property p_fault_trap;
    @(posedge clk) disable iff (!nrst)
    fault_set |=> ##1 (data_access_trap || coproc_trap);
  endproperty
  a_fault_trap: assert property (p_fault_trap) else $error("data error raised no trap");

  property p_fault_state;
    @(posedge clk) disable iff (!nrst)
    chan_r[CC_FAULT_BIT] |-> chan_state_r == CH_FAULT;
  endproperty
  a_fault_state: assert property (p_fault_state) else $error("fault bit set outside fault state");

  property p_lock_only;
    @(posedge clk) disable iff (!nrst)
    (xfer_valid && !status_r[CS_FREEZE_BIT] && !xfer_is_lock) |=> !chan_r[CC_LOCK_BIT];
  endproperty
  a_lock_only: assert property (p_lock_only) else $error("lock bit set without lock transfer");

  property p_guard_super;
    @(posedge clk) disable iff (!nrst)
    !user_mode |=> !protection_trap;
  endproperty
  a_guard_super: assert property (p_guard_super) else $error("protection trap outside user mode");

  property p_guard_user;
    @(posedge clk) disable iff (!nrst)
    (gpr_access && user_mode && gpr_abs_num[7:4] != 4'h0 && guard_r[gpr_abs_num[7:4]]) |=> protection_trap;
  endproperty
  a_guard_user: assert property (p_guard_user) else $error("guarded bank access not trapped");

  property p_irq_gate;
    @(posedge clk) disable iff (!nrst)
    timer_irq |-> $past(texpired) && $past(allow_r) && !$past(status_r[CS_TRAP_DIS_BIT]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("timer interrupt not gated");

  property p_decode_hold;
    @(posedge clk) disable iff (!nrst)
    (status_r[CS_FREEZE_BIT] && !wr_dec) |=> $stable(pc_dec_r);
  endproperty
  a_decode_hold: assert property (p_decode_hold) else $error("decode address moved under freeze");

  property p_execute_cap;
    @(posedge clk) disable iff (!nrst)
    (execute_enter && !status_r[CS_FREEZE_BIT]) |=> ##1 restart_execute_addr == {$past(execute_pc[31:2], 2), 2'b00};
  endproperty
  a_execute_cap: assert property (p_execute_cap) else $error("execute address not captured");
endmodule : spr_group
`default_nettype wire

// file: include/spr_group_pkg.sv
// Constants for the channel, bank guard, timer and pipeline address register group
package spr_group_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFF_CHANNEL_CONTROL = 4'h6;
  localparam logic [3:0] OFF_BANK_GUARD = 4'h7;
  localparam logic [3:0] OFF_TIMER_COUNT = 4'h8;
  localparam logic [3:0] OFF_TIMER_RELOAD = 4'h9;
  localparam logic [3:0] OFF_DECODE_ADDR = 4'ha;
  localparam logic [3:0] OFF_EXECUTE_ADDR = 4'hb;
  localparam logic [3:0] OFF_CORE_STATUS = 4'hc;
  // Channel control field positions
  localparam int unsigned CC_INSN_LSB = 24;
  localparam int unsigned CC_COUNT_LSB = 16;
  localparam int unsigned CC_DIR_BIT = 15;
  localparam int unsigned CC_MULTI_BIT = 14;
  localparam int unsigned CC_SET_BIT = 13;
  localparam int unsigned CC_LOCK_BIT = 12;
  localparam int unsigned CC_FAULT_BIT = 10;
  localparam int unsigned CC_REG_LSB = 2;
  localparam int unsigned CC_UNUSED_BIT = 1;
  localparam int unsigned CC_VALID_BIT = 0;
  // Timer reload field positions
  localparam int unsigned TR_OVERRUN_BIT = 26;
  localparam int unsigned TR_EXPIRED_BIT = 25;
  localparam int unsigned TR_ALLOW_BIT = 24;
  localparam int unsigned TIMER_W = 24;
  // Bank layout
  localparam int unsigned NUM_BANKS = 16;
  localparam int unsigned BANK_SIZE = 16;
  localparam int unsigned BANK0_SIZE = 12;
  // Core status register (own register) bit positions
  localparam int unsigned CS_FREEZE_BIT = 0;
  localparam int unsigned CS_TRAP_DIS_BIT = 1;
  localparam int unsigned CS_SUPER_BIT = 2;
  localparam int unsigned CS_MONITOR_BIT = 3;
  localparam int unsigned CS_CPU_LOCK_BIT = 4;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [TIMER_W-1:0] TIMER_RESET = 24'h00_0000;
  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_MULTI = 2'b01,
    CH_FAULT = 2'b10
  } chan_state_e;
endpackage : spr_group_pkg

// file: hw/spr_timer.sv
// Down-counting interval timer with reload, expiry and overrun status
`timescale 1ns/1ps
`default_nettype none
module spr_timer
  import spr_group_pkg::*;
#(
  parameter int unsigned WIDTH = TIMER_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic count_wr,
  input wire logic [WIDTH-1:0] count_wdata,
  input wire logic reload_wr,
  input wire logic [WIDTH-1:0] reload_wdata,
  input wire logic expired_wdata,
  input wire logic overrun_wdata,
  output logic [WIDTH-1:0] count_r,
  output logic [WIDTH-1:0] reload_r,
  output logic expired_r,
  output logic overrun_r,
  output logic zero_hit
);
  initial begin
    if (WIDTH < 2 || WIDTH > 32) $error("spr_timer: WIDTH out of range");
  end

  // Zero is held one whole cycle, then the reload and the expiry happen together
  assign zero_hit = (count_r == '0) && !count_wr;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_r <= '0;
    end else if (count_wr) begin
      count_r <= count_wdata;
    end else if (zero_hit) begin
      count_r <= reload_r;
    end else begin
      count_r <= count_r - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reload_r <= '0;
    end else if (reload_wr) begin
      reload_r <= reload_wdata;
    end
  end

  // Hardware set beats a software clear in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      expired_r <= 1'b0;
    end else if (zero_hit) begin
      expired_r <= 1'b1;
    end else if (reload_wr) begin
      expired_r <= expired_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      overrun_r <= 1'b0;
    end else if (zero_hit && expired_r) begin
      overrun_r <= 1'b1;
    end else if (reload_wr) begin
      overrun_r <= overrun_wdata;
    end
  end

  property p_timer_reload;
    @(posedge clk) disable iff (!nrst)
    zero_hit |=> (count_r == $past(reload_r)) && expired_r;
  endproperty
  a_timer_reload: assert property (p_timer_reload) else $error("timer missed reload or expiry");

  property p_timer_overrun;
    @(posedge clk) disable iff (!nrst)
    (zero_hit && expired_r) |=> overrun_r;
  endproperty
  a_timer_overrun: assert property (p_timer_overrun) else $error("timer overrun not flagged");

  sequence s_count_two;
    !count_wr && !reload_wr && count_r == WIDTH'(2) ##1 !count_wr && !reload_wr ##1 !count_wr;
  endsequence
  property p_timer_interval;
    @(posedge clk) disable iff (!nrst)
    s_count_two |=> expired_r;
  endproperty
  a_timer_interval: assert property (p_timer_interval) else $error("timer interval not N+1");
endmodule : spr_timer
`default_nettype wire

// file: bench/spr_group_tb.sv
// Self-checking testbench for the channel, bank guard, timer and pipeline address group
`timescale 1ns/1ps
`default_nettype none
module spr_group_tb;
  import spr_group_pkg::*;
  localparam logic [7:0] GNUM [0:5] = '{8'h02, 8'h05, 8'h11, 8'h28, 8'hf3, 8'he0};
  localparam logic [5:0] GEXP = 6'b010110;
  localparam logic [31:0] MODES [0:2] = '{32'h0000_0000, 32'h0000_0008, 32'h0000_0004};
  logic clk, nrst, reg_wr, reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, decode_pc, execute_pc, restart_decode_addr, restart_execute_addr;
  logic xfer_valid, xfer_is_load, xfer_is_multi_partial, xfer_is_set, xfer_is_lock, xfer_coproc_select;
  logic data_error_input, load_overwritten, record_invalidate, gpr_access, decode_enter, execute_enter;
  logic [7:0] xfer_insn_bits, xfer_remaining, xfer_reg_num, gpr_abs_num;
  logic data_access_trap, coproc_trap, protection_trap, timer_irq, freeze_bit;
  int miscompares, check_count, k;
  spr_group dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xfer_valid(xfer_valid), .xfer_insn_bits(xfer_insn_bits),
    .xfer_remaining(xfer_remaining), .xfer_is_load(xfer_is_load), .xfer_is_multi_partial(xfer_is_multi_partial),
    .xfer_is_set(xfer_is_set), .xfer_is_lock(xfer_is_lock), .xfer_reg_num(xfer_reg_num),
    .xfer_coproc_select(xfer_coproc_select), .data_error_input(data_error_input),
    .load_overwritten(load_overwritten), .record_invalidate(record_invalidate), .gpr_access(gpr_access),
    .gpr_abs_num(gpr_abs_num), .decode_enter(decode_enter), .decode_pc(decode_pc),
    .execute_enter(execute_enter), .execute_pc(execute_pc), .data_access_trap(data_access_trap),
    .coproc_trap(coproc_trap), .protection_trap(protection_trap), .timer_irq(timer_irq),
    .freeze_bit(freeze_bit), .restart_decode_addr(restart_decode_addr),
    .restart_execute_addr(restart_execute_addr));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input string name, input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(name, exp, reg_rdata);
  endtask : rd_chk
  // Flags are load, multi, set, lock, coprocessor select, data error
  task automatic xfer(input logic [7:0] insn, input logic [7:0] rem, input logic [5:0] f, input logic [7:0] rn);
    @(posedge clk);
    xfer_valid <= 1'b1;
    xfer_insn_bits <= insn;
    xfer_remaining <= rem;
    {xfer_is_load, xfer_is_multi_partial, xfer_is_set, xfer_is_lock, xfer_coproc_select, data_error_input} <= f;
    xfer_reg_num <= rn;
    @(posedge clk);
    xfer_valid <= 1'b0;
    data_error_input <= 1'b0;
  endtask : xfer
  task automatic stage_enter(input logic [31:0] dpc, input logic [31:0] epc);
    @(posedge clk);
    decode_enter <= 1'b1;
    decode_pc <= dpc;
    execute_enter <= 1'b1;
    execute_pc <= epc;
    @(posedge clk);
    decode_enter <= 1'b0;
    execute_enter <= 1'b0;
  endtask : stage_enter
  // Expected channel word; f holds load, multi, set, lock and the record is always valid here
  function automatic logic [31:0] cc(input logic [7:0] insn, input logic [7:0] rem, input logic [3:0] f,
    input logic flt, input logic [7:0] rn, input logic nn);
    cc = (32'(insn) << CC_INSN_LSB) | (32'(rem) << CC_COUNT_LSB) | (32'(f) << CC_LOCK_BIT);
    cc = cc | (32'(flt) << CC_FAULT_BIT) | (32'(rn) << CC_REG_LSB) | (32'(nn) << CC_UNUSED_BIT) | 32'h0000_0001;
  endfunction : cc
  initial begin
    nrst = 1'b0;
    {reg_wr, reg_rd, xfer_valid, xfer_is_load, xfer_is_multi_partial, xfer_is_set, xfer_is_lock} = '0;
    {xfer_coproc_select, data_error_input, load_overwritten, record_invalidate, gpr_access} = '0;
    {decode_enter, execute_enter} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    {xfer_insn_bits, xfer_remaining, xfer_reg_num, gpr_abs_num} = '0;
    decode_pc = '0;
    execute_pc = '0;
    miscompares = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd_chk("core_status", OFF_CORE_STATUS, 32'h0000_0004);
    rd_chk("unmapped", 4'h0, 32'h0000_0000);
    wr(4'h1, 32'hffff_ffff);
    rd_chk("unmapped_after_write", 4'h1, 32'h0000_0000);
    wr(OFF_BANK_GUARD, 32'h0000_a5a5);
    rd_chk("bank_guard", OFF_BANK_GUARD, 32'h0000_a5a5);
    // CPU lock set in status so a leak into the lock field would show
    wr(OFF_CORE_STATUS, 32'h0000_0014);
    xfer(8'ha5, 8'h1c, 6'b111000, 8'h9c);
    rd_chk("cc_multi_load", OFF_CHANNEL_CONTROL, cc(8'ha5, 8'h1c, 4'b1110, 1'b0, 8'h9c, 1'b0));
    @(posedge clk);
    load_overwritten <= 1'b1;
    @(posedge clk);
    load_overwritten <= 1'b0;
    rd_chk("cc_unused", OFF_CHANNEL_CONTROL, cc(8'ha5, 8'h1c, 4'b1110, 1'b0, 8'h9c, 1'b1));
    @(posedge clk);
    record_invalidate <= 1'b1;
    @(posedge clk);
    record_invalidate <= 1'b0;
    rd_chk("cc_invalid", OFF_CHANNEL_CONTROL, cc(8'ha5, 8'h1c, 4'b1110, 1'b0, 8'h9c, 1'b1) - 32'd1);
    xfer(8'h3c, 8'h07, 6'b000101, 8'h21);
    rd_chk("cc_locked_store", OFF_CHANNEL_CONTROL, cc(8'h3c, 8'h00, 4'b0001, 1'b1, 8'h21, 1'b0));
    check("data_trap_set", 32'h1, data_access_trap);
    check("coproc_trap_idle", 32'h0, coproc_trap);
    wr(OFF_CHANNEL_CONTROL, 32'h0000_0000);
    repeat (2) @(posedge clk);
    #1;
    check("data_trap_cleared", 32'h0, data_access_trap);
    xfer(8'h42, 8'h00, 6'b100011, 8'h80);
    rd_chk("cc_coproc_fault", OFF_CHANNEL_CONTROL, cc(8'h42, 8'h00, 4'b1000, 1'b1, 8'h80, 1'b0));
    check("coproc_trap_set", 32'h1, coproc_trap);
    check("data_trap_idle", 32'h0, data_access_trap);
    wr(OFF_CHANNEL_CONTROL, 32'h0000_0000);
    stage_enter(32'h1234_5677, 32'h89ab_cdec);
    rd_chk("decode_addr", OFF_DECODE_ADDR, 32'h1234_5674);
    rd_chk("execute_addr", OFF_EXECUTE_ADDR, 32'h89ab_cdec);
    check("restart_decode", 32'h1234_5674, restart_decode_addr);
    check("restart_execute", 32'h89ab_cdec, restart_execute_addr);
    // Frozen: stage entries and transfers must leave the saved state alone
    wr(OFF_CORE_STATUS, 32'h0000_0005);
    stage_enter(32'h0bad_0f00, 32'h0fee_0ba0);
    xfer(8'h11, 8'h22, 6'b110000, 8'h33);
    check("freeze_bit", 32'h1, freeze_bit);
    rd_chk("decode_frozen", OFF_DECODE_ADDR, 32'h1234_5674);
    rd_chk("execute_frozen", OFF_EXECUTE_ADDR, 32'h89ab_cdec);
    rd_chk("cc_frozen", OFF_CHANNEL_CONTROL, 32'h0000_0000);
    wr(OFF_BANK_GUARD, 32'h0000_8003);
    for (int m = 0; m < 3; m++) begin
      wr(OFF_CORE_STATUS, MODES[m]);
      for (int i = 0; i < 6; i++) begin
        @(posedge clk);
        gpr_access <= 1'b1;
        gpr_abs_num <= GNUM[i];
        @(posedge clk);
        gpr_access <= 1'b0;
        #1;
        check("protection_trap", (m == 0) ? GEXP[i] : 1'b0, protection_trap);
      end
    end
    // Reload value first; the last write clears the flags while the count is far from zero
    wr(OFF_TIMER_RELOAD, 32'h0000_0005);
    wr(OFF_TIMER_COUNT, 32'h0000_0014);
    wr(OFF_TIMER_RELOAD, 32'h0100_0005);
    #1;
    k = 2;
    while (timer_irq !== 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
      #1;
    end
    check("irq_delay", 32'd22, 32'(k));
    // A timed-out wait has already counted its mismatch and skips to the report
    if (k < 100) begin
      repeat (10) @(posedge clk);
      rd_chk("timer_status", OFF_TIMER_RELOAD, 32'h0700_0005);
      wr(OFF_CORE_STATUS, 32'h0000_0006);
      repeat (2) @(posedge clk);
      #1;
      check("irq_trap_disabled", 32'h0, timer_irq);
      wr(OFF_CORE_STATUS, 32'h0000_0004);
      repeat (2) @(posedge clk);
      #1;
      check("irq_reenabled", 32'h1, timer_irq);
      wr(OFF_TIMER_RELOAD, 32'h0000_0005);
      repeat (2) @(posedge clk);
      #1;
      check("irq_blocked", 32'h0, timer_irq);
    end
    summarize();
  end
endmodule : spr_group_tb
`default_nettype wire
